// ---- hw/frl_pkg.sv ----
// Shared constants and types for the regulator fault-response block
package frl_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned TD1_NS        = 1_100_000;
    localparam int unsigned TD1_CYCLES    =
        (TD1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RETRY_FACTOR  = 8;
    localparam int unsigned RETRY_CYCLES  = RETRY_FACTOR * TD1_CYCLES;
    localparam int unsigned HOLD_NS       = 50_000;
    localparam int unsigned HOLD_CYCLES   =
        (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HOLD_W        = 10;

    // ****************************************************************
    // Structure and reset values
    // ****************************************************************
    localparam int unsigned PHASES        = 3;
    localparam int unsigned SYNC_STAGES   = 2;
    localparam logic        PG_PIN_LEVEL  = 1'b0;
    localparam logic        GATE_RST      = 1'b0;
    localparam logic        PG_LOW_RST    = 1'b1;

    // Analog comparator outputs and the transition indication
    typedef struct packed {
        logic uv_below;
        logic uv_recover;
        logic ov_trip;
        logic avg_oc_nom;
        logic avg_oc_boost;
        logic mon_oc;
        logic vid_transition;
    } frl_cmp_type;

    typedef enum logic [5:0] {
        ST_OFF     = 6'h01,
        ST_DELAY   = 6'h02,
        ST_RAMP    = 6'h04,
        ST_RUN     = 6'h08,
        ST_OC_WAIT = 6'h10,
        ST_LATCH   = 6'h20
    } frl_state_type;

endpackage

// ---- hw/frl_sync.sv ----
// Two-stage synchroniser for comparator levels
`timescale 1ns/1ps
module frl_sync
    import frl_pkg::*;
#(
    parameter int unsigned WIDTH = 1
)
(
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    generate
        if (WIDTH < 1)
        begin : g_bad_width
            $error("frl_sync: WIDTH must be at least 1");
        end
    endgenerate

    // First stage feeds only the second
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule

// ---- hw/frl_phase_limit.sv ----
// Gate command override for one phase
`timescale 1ns/1ps
module frl_phase_limit
    import frl_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic run,
    input  wire logic clamp_low,
    input  wire logic pwm_hs,
    input  wire logic pwm_ls,
    input  wire logic limit_hit,
    output logic      hs_cmd,
    output logic      ls_cmd
);
    logic hs_ff;
    logic ls_ff;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hs_ff <= GATE_RST;
            ls_ff <= GATE_RST;
        end
        else
        begin
            // High side stays blocked while the limit holds
            hs_ff <= run & pwm_hs & ~limit_hit;
            ls_ff <= clamp_low | (run & (pwm_ls | limit_hit));
        end
    end

    assign hs_cmd = hs_ff;
    assign ls_cmd = ls_ff;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_limit_force: assert property (@(posedge clk) disable iff (!reset_n)
        (run && limit_hit) |=> (!hs_ff && ls_ff))
        else $error("limited phase not forced low side");
    a_limit_block: assert property (@(posedge clk) disable iff (!reset_n)
        limit_hit |=> !hs_ff)
        else $error("high side rose during current limit");
endmodule

// ---- hw/frl_fault_ctrl.sv ----
// Regulator fault response: power good, latch-off, hiccup and limits
`timescale 1ns/1ps
module frl_fault_ctrl
    import frl_pkg::*;
#(
    parameter int unsigned NUM_PHASES   = PHASES,
    parameter int unsigned TD1_LEN      = TD1_CYCLES,
    parameter int unsigned RETRY_LEN    = RETRY_CYCLES
)
(
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic                  enable,
    input  wire frl_pkg::frl_cmp_type  cmp_in,
    input  wire logic [NUM_PHASES-1:0] chan_oc_nom,
    input  wire logic [NUM_PHASES-1:0] chan_oc_boost,
    input  wire logic                  softstart_ramp_done,
    input  wire logic [NUM_PHASES-1:0] pwm_hs,
    input  wire logic [NUM_PHASES-1:0] pwm_ls,
    output logic      [NUM_PHASES-1:0] high_side_gate_cmd,
    output logic      [NUM_PHASES-1:0] low_side_gate_cmd,
    output logic                       power_good_out_o,
    output logic                       power_good_out_oe,
    output logic                       regulate_en,
    output logic                       latched_off,
    output logic                       threshold_boost
);
    import frl_pkg::*;

    localparam int unsigned CMP_W = $bits(frl_cmp_type);
    localparam int unsigned SYN_W = CMP_W + 2 * NUM_PHASES;
    localparam int unsigned CNT_W = $clog2(RETRY_LEN + 1);
    localparam logic [CNT_W-1:0] TD1_LOAD   = CNT_W'(TD1_LEN - 1);
    localparam logic [CNT_W-1:0] RETRY_LOAD = CNT_W'(RETRY_LEN - 1);
    localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYCLES);

    generate
        if (NUM_PHASES < 1 || TD1_LEN < 1 || RETRY_LEN < TD1_LEN ||
            HOLD_CYCLES >= (1 << HOLD_W))
        begin : g_bad_cfg
            $error("frl_fault_ctrl: unsupported parameter values");
        end
    endgenerate

    // ****************************************************************
    // Input synchronisation
    // ****************************************************************
    frl_cmp_type            cmp;
    logic [NUM_PHASES-1:0]  oc_nom_s;
    logic [NUM_PHASES-1:0]  oc_boost_s;
    logic [SYN_W-1:0]       syn_bus;

    // Comparators are analog, so every level is brought in here
    frl_sync #(
        .WIDTH (SYN_W)
    ) u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in ({cmp_in, chan_oc_nom, chan_oc_boost}),
        .sync_out (syn_bus)
    );

    assign cmp        = frl_cmp_type'(syn_bus[SYN_W-1 -: CMP_W]);
    assign oc_nom_s   = syn_bus[2*NUM_PHASES-1 -: NUM_PHASES];
    assign oc_boost_s = syn_bus[NUM_PHASES-1:0];

    // ****************************************************************
    // Transition hold-off and threshold selection
    // ****************************************************************
    logic [HOLD_W-1:0]      hold_cnt_ff;
    logic                   boost_ff;
    logic                   boost_sel;
    logic                   avg_hit;
    logic                   oc_hit;
    logic [NUM_PHASES-1:0]  chan_hit;

    // Reload every cycle of the transition so the 50us runs from its end
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            hold_cnt_ff <= '0;
        else if (cmp.vid_transition)
            hold_cnt_ff <= HOLD_LOAD;
        else if (hold_cnt_ff != '0)
            hold_cnt_ff <= hold_cnt_ff - 1'b1;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            boost_ff <= 1'b0;
        else
            boost_ff <= cmp.vid_transition | (hold_cnt_ff > 1);
    end

    // Raised comparators avoid false trips while the reference slews;
    // the live transition bit covers the cycle before boost_ff rises
    assign boost_sel = cmp.vid_transition | boost_ff;
    assign avg_hit   = boost_sel ? cmp.avg_oc_boost : cmp.avg_oc_nom;
    assign oc_hit    = avg_hit | cmp.mon_oc;
    assign chan_hit  = boost_sel ? oc_boost_s : oc_nom_s;

    // ****************************************************************
    // Sequence state machine
    // ****************************************************************
    frl_state_type          st_ff;
    frl_state_type          nxt_st;
    logic [CNT_W-1:0]       cnt_ff;
    logic                   active;

    assign active = (st_ff == ST_RAMP) || (st_ff == ST_RUN);

    always_comb
    begin
        nxt_st = st_ff;
        case (st_ff)
            ST_OFF:
                nxt_st = ST_DELAY;
            ST_DELAY:
                if (cnt_ff == '0)
                    nxt_st = ST_RAMP;
            ST_RAMP, ST_RUN:
                if (cmp.ov_trip)
                    nxt_st = ST_LATCH;
                else if (oc_hit)
                    nxt_st = ST_OC_WAIT;
                else if (st_ff == ST_RAMP && softstart_ramp_done)
                    nxt_st = ST_RUN;
            ST_OC_WAIT:
                if (cnt_ff == '0)
                    nxt_st = ST_DELAY;
            ST_LATCH:
                nxt_st = ST_LATCH;
            default:
                nxt_st = ST_OFF;
        endcase
        // Disable ends any retry loop or latch
        if (!enable)
            nxt_st = ST_OFF;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            st_ff <= ST_OFF;
        else
            st_ff <= nxt_st;
    end

    // One counter serves both the startup delay and the retry wait
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            cnt_ff <= '0;
        else if (nxt_st == ST_DELAY && st_ff != ST_DELAY)
            cnt_ff <= TD1_LOAD;
        else if (nxt_st == ST_OC_WAIT && st_ff != ST_OC_WAIT)
            cnt_ff <= RETRY_LOAD;
        else if (cnt_ff != '0)
            cnt_ff <= cnt_ff - 1'b1;
    end

    // ****************************************************************
    // Power good
    // ****************************************************************
    logic uv_flag_ff;
    logic nxt_uv;
    logic pg_low_ff;

    // A new undervoltage wins over a recovery in the same cycle
    always_comb
    begin
        nxt_uv = uv_flag_ff;
        if (cmp.uv_recover)
            nxt_uv = 1'b0;
        if (cmp.uv_below)
            nxt_uv = 1'b1;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            uv_flag_ff <= 1'b0;
        else
            uv_flag_ff <= nxt_uv;
    end

    // Undervoltage touches only this pin; per-phase limits never do
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            pg_low_ff <= PG_LOW_RST;
        else
            pg_low_ff <= (st_ff != ST_RUN) | nxt_uv;
    end

    assign power_good_out_o  = PG_PIN_LEVEL;
    assign power_good_out_oe = pg_low_ff;

    // ****************************************************************
    // Status outputs
    // ****************************************************************
    logic reg_en_ff;
    logic latch_ff;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reg_en_ff <= 1'b0;
            latch_ff  <= 1'b0;
        end
        else
        begin
            reg_en_ff <= active;
            latch_ff  <= (st_ff == ST_LATCH);
        end
    end

    assign regulate_en     = reg_en_ff;
    assign latched_off     = latch_ff;
    assign threshold_boost = boost_ff;

    // ****************************************************************
    // Per-phase gate overrides
    // ****************************************************************
    logic clamp_low;

    // While latched, an overvoltage still pulls low sides on
    assign clamp_low = (st_ff == ST_LATCH) & cmp.ov_trip;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PHASES; gi++)
        begin : g_phase
            frl_phase_limit u_limit (
                .clk       (clk),
                .reset_n   (reset_n),
                .run       (active),
                .clamp_low (clamp_low),
                .pwm_hs    (pwm_hs[gi]),
                .pwm_ls    (pwm_ls[gi]),
                .limit_hit (chan_hit[gi]),
                .hs_cmd    (high_side_gate_cmd[gi]),
                .ls_cmd    (low_side_gate_cmd[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_uv_pg_low: assert property (
        (cmp.uv_below) |=> pg_low_ff)
        else $error("power good not low on undervoltage");
    a_uv_release: assert property (
        (st_ff == ST_RUN && nxt_st == ST_RUN && uv_flag_ff &&
         cmp.uv_recover && !cmp.uv_below) |=> !pg_low_ff)
        else $error("power good not released after recovery");
    a_ov_latch: assert property (
        (active && cmp.ov_trip && enable) |=> (st_ff == ST_LATCH)
        ##1 latched_off)
        else $error("overvoltage did not latch off");
    a_latch_hold: assert property (
        (st_ff == ST_LATCH && enable) |=> (st_ff == ST_LATCH))
        else $error("latch left while enabled");
    a_oc_start: assert property (
        (active && !cmp.ov_trip && enable && avg_hit)
        |=> (st_ff == ST_OC_WAIT))
        else $error("average overcurrent ignored");
    a_boost_sel: assert property (
        (cmp.vid_transition) |=> boost_ff && hold_cnt_ff == HOLD_LOAD)
        else $error("raised threshold not selected");
    a_boost_end: assert property (
        (!cmp.vid_transition && hold_cnt_ff == 1) |=> !boost_ff)
        else $error("raised threshold held too long");
    a_mon_start: assert property (
        (active && !cmp.ov_trip && enable && cmp.mon_oc)
        |=> (st_ff == ST_OC_WAIT))
        else $error("monitor overcurrent ignored");
    a_oc_gates_off: assert property (
        $rose(st_ff == ST_OC_WAIT) |=> (high_side_gate_cmd == '0 &&
        low_side_gate_cmd == '0 && power_good_out_oe))
        else $error("gates not off in shutdown");
    a_retry_wait: assert property (
        $rose(st_ff == ST_OC_WAIT) |-> (cnt_ff == RETRY_LOAD))
        else $error("retry wait length wrong");
    a_retry_go: assert property (
        (st_ff == ST_OC_WAIT && cnt_ff == '0 && enable)
        |=> (st_ff == ST_DELAY && cnt_ff == TD1_LOAD))
        else $error("retry did not restart soft-start");
    a_chan_local: assert property (
        (st_ff == ST_RUN && enable && !cmp.ov_trip && !oc_hit &&
         |chan_hit) |=> (st_ff == ST_RUN))
        else $error("phase limit changed regulator state");
    a_pg_pre_ss: assert property (
        (st_ff != ST_RUN) |=> power_good_out_oe)
        else $error("power good high before soft-start end");

    c_oc_retry: cover property (
        (st_ff == ST_OC_WAIT) ##1 (st_ff == ST_DELAY));
    c_uv_event: cover property (
        (st_ff == ST_RUN && cmp.uv_below) ##[1:20] !pg_low_ff);
    c_ov_latch: cover property (st_ff == ST_LATCH);
    c_boost: cover property ($fell(boost_ff));
endmodule

// ---- sim/frl_stage_model.sv ----
// Behavioural power stage and analog comparators facing the fault block
`timescale 1ns/1ps
module frl_stage_model
    import frl_pkg::*;
#(
    parameter int unsigned RAMP_LEN = 6
)
(
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic               regulate_en,
    input  wire logic [1:0]         uv_level,
    input  wire logic               ov_req,
    input  wire logic [1:0]         avg_req,
    input  wire logic               mon_req,
    input  wire logic               vid_req,
    input  wire logic [PHASES-1:0]  chan_nom_req,
    input  wire logic [PHASES-1:0]  chan_boost_req,
    output frl_pkg::frl_cmp_type    cmp,
    output logic      [PHASES-1:0]  chan_oc_nom,
    output logic      [PHASES-1:0]  chan_oc_boost,
    output logic                    softstart_ramp_done,
    output logic      [PHASES-1:0]  pwm_hs,
    output logic      [PHASES-1:0]  pwm_ls
);
    import frl_pkg::*;

    logic [2:0] pwm_cnt  = 3'h0;
    int         ramp_cnt = 0;
    logic       flow;

    // Updates land just after the edge, like every other stimulus
    always
    begin
        @(posedge clk);
        #10;
        if (!reset_n)
        begin
            pwm_cnt = 3'h0;
            ramp_cnt = 0;
        end
        else
        begin
            pwm_cnt = pwm_cnt + 3'h1;
            ramp_cnt = regulate_en ? ramp_cnt + 1 : 0;
        end
    end

    // Inductor current only exists while the stage switches
    assign flow                = regulate_en;
    assign softstart_ramp_done = (ramp_cnt >= RAMP_LEN);
    assign pwm_hs              = {pwm_cnt[2], ~pwm_cnt[2], pwm_cnt[2]};
    assign pwm_ls              = ~pwm_hs;
    // Output is low until the ramp has brought it up
    // One driver for the whole struct, fields in declared order
    assign cmp = {
        (uv_level == 2'h2) || !softstart_ramp_done,
        (uv_level == 2'h0) && softstart_ramp_done,
        ov_req,
        flow && (avg_req != 2'h0),
        flow && (avg_req == 2'h2),
        flow && mon_req,
        vid_req
    };
    assign chan_oc_nom   = {PHASES{flow}} & (chan_nom_req | chan_boost_req);
    assign chan_oc_boost = {PHASES{flow}} & chan_boost_req;
endmodule

// ---- sim/frl_fault_ctrl_tb_top.sv ----
// Self-checking bench for the regulator fault-response block
`timescale 1ns/1ps
module frl_fault_ctrl_tb_top;
    import frl_pkg::*;

    localparam int TD1_T   = 8;
    localparam int RETRY_T = 64;
    localparam int RAMP_T  = 6;
    localparam int CEIL    = 6000;
    localparam int PG      = 0;
    localparam int RUN     = 1;
    localparam int LAT     = 2;
    localparam int BST     = 3;

    logic              clk            = 1'b0;
    logic              reset_n        = 1'b0;
    logic              enable         = 1'b0;
    logic [1:0]        uv_level       = 2'h0;
    logic              ov_req         = 1'b0;
    logic [1:0]        avg_req        = 2'h0;
    logic              mon_req        = 1'b0;
    logic              vid_req        = 1'b0;
    logic [2:0]        chan_nom_req   = 3'h0;
    logic [2:0]        chan_boost_req = 3'h0;
    frl_cmp_type       cmp;
    logic [2:0]        chan_oc_nom, chan_oc_boost, pwm_hs, pwm_ls;
    logic              ramp_done;
    logic [2:0]        hs, ls;
    logic              pg_o, pg_oe, regulate_en, latched_off, boost;
    int                n_mismatch     = 0;
    int                total_checks   = 0;
    int                cyc            = 0;

    always #50 clk = ~clk;

    frl_stage_model #(.RAMP_LEN(RAMP_T)) stage (
        .clk(clk), .reset_n(reset_n), .regulate_en(regulate_en),
        .uv_level(uv_level), .ov_req(ov_req), .avg_req(avg_req),
        .mon_req(mon_req), .vid_req(vid_req), .chan_nom_req(chan_nom_req),
        .chan_boost_req(chan_boost_req), .cmp(cmp),
        .chan_oc_nom(chan_oc_nom), .chan_oc_boost(chan_oc_boost),
        .softstart_ramp_done(ramp_done), .pwm_hs(pwm_hs), .pwm_ls(pwm_ls));

    frl_fault_ctrl #(.TD1_LEN(TD1_T), .RETRY_LEN(RETRY_T)) dut (
        .clk(clk), .reset_n(reset_n), .enable(enable), .cmp_in(cmp),
        .chan_oc_nom(chan_oc_nom), .chan_oc_boost(chan_oc_boost),
        .softstart_ramp_done(ramp_done), .pwm_hs(pwm_hs), .pwm_ls(pwm_ls),
        .high_side_gate_cmd(hs), .low_side_gate_cmd(ls),
        .power_good_out_o(pg_o), .power_good_out_oe(pg_oe),
        .regulate_en(regulate_en), .latched_off(latched_off),
        .threshold_boost(boost));

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Hang guard: a stuck wait ends the run as a failure
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == CEIL)
        begin
            n_mismatch++;
            $display("[ERR] %0t timeout", $time);
            results();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t %s: seen %0h exp %0h", $time, msg, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clk);
            #10;
        end
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            PG:      return pg_oe;
            RUN:     return regulate_en;
            LAT:     return latched_off;
            default: return boost;
        endcase
    endfunction

    task automatic wait_for(input int sel, input logic v, input int mx,
                            output int n);
        n = 0;
        while (pick(sel) !== v && n < mx)
        begin
            tick(1);
            n++;
        end
    endtask

    // Phase p clamped: high side off, low side on, while pwm toggles
    task automatic chk_clamp(input int p, input string msg);
        int bad;
        bad = 0;
        repeat (8)
        begin
            if (hs[p] !== 1'b0 || ls[p] !== 1'b1)
                bad++;
            tick(1);
        end
        chk(bad, 0, msg);
    endtask

    task automatic t_start;
        int n;
        enable = 1'b1;
        wait_for(RUN, 1'b1, TD1_T + 8, n);
        chk(n >= TD1_T, 1, "startup delay short");
        chk(pg_oe, 1, "pg high before ramp end");
        wait_for(PG, 1'b0, RAMP_T + 12, n);
        chk(n >= RAMP_T, 1, "pg released during ramp");
        chk({pg_oe, pg_o}, 2'b00, "pg not released");
    endtask

    task automatic t_uv;
        int n;
        uv_level = 2'h2;
        tick(1);
        chk(pg_oe, 0, "pg reacts before sync");
        wait_for(PG, 1'b1, 6, n);
        chk(pg_oe, 1, "uv pg not low");
        tick(8);
        chk({regulate_en, latched_off}, 2'b10, "uv took action");
        uv_level = 2'h1;
        tick(10);
        chk(pg_oe, 1, "pg released below recovery");
        uv_level = 2'h0;
        wait_for(PG, 1'b0, 6, n);
        chk(pg_oe, 0, "pg not back");
    endtask

    task automatic t_limit;
        logic seen;
        logic other;
        for (int p = 0; p < 3; p++)
        begin
            chan_nom_req = 3'h1 << p;
            tick(4);
            other = 1'b0;
            for (int i = 0; i < 8; i++)
            begin
                other |= hs[(p + 1) % 3];
                tick(1);
            end
            chk_clamp(p, "phase not limited");
            chk(other, 1, "neighbour phase stalled");
            chk({regulate_en, pg_oe}, 2'b10, "limit hit regulator");
            chan_nom_req = 3'h0;
            seen = 1'b0;
            repeat (10)
            begin
                seen |= hs[p];
                tick(1);
            end
            chk(seen, 1, "high side still blocked");
        end
    endtask

    task automatic t_boost;
        int n;
        logic seen;
        vid_req = 1'b1;
        avg_req = 2'h1;
        chan_nom_req = 3'h1;
        wait_for(BST, 1'b1, 6, n);
        chk(boost, 1, "no boost");
        seen = 1'b0;
        repeat (10)
        begin
            seen |= hs[0];
            tick(1);
        end
        chk(seen, 1, "nominal phase limit in boost");
        chk(regulate_en, 1, "nominal avg trip in boost");
        chan_boost_req = 3'h1;
        tick(4);
        chk_clamp(0, "raised phase limit ignored");
        chan_boost_req = 3'h0;
        vid_req = 1'b0;
        tick(300);
        avg_req = 2'h0;
        tick(150);
        chk({boost, regulate_en}, 2'b11, "boost ended early");
        wait_for(BST, 1'b0, 60, n);
        chk(boost, 0, "boost stuck");
        tick(4);
        chk_clamp(0, "nominal limit not back");
        chan_nom_req = 3'h0;
        tick(4);
    endtask

    task automatic t_ocp(input int kind);
        int n;
        int bad;
        if (kind == 0)
            avg_req = 2'h1;
        else
            mon_req = 1'b1;
        wait_for(RUN, 1'b0, 8, n);
        if (kind == 0)
            chk(regulate_en, 0, "avg no shutdown");
        else
            chk(regulate_en, 0, "monitor no shutdown");
        tick(1);
        n = 0;
        bad = 0;
        while (regulate_en !== 1'b1 && n < RETRY_T + TD1_T + 8)
        begin
            if ({hs, ls, pg_oe} !== 7'h01)
                bad++;
            tick(1);
            n++;
        end
        chk(bad, 0, "gates or pg during shutdown");
        chk(n >= RETRY_T + TD1_T - 4, 1, "retry too soon");
        chk(regulate_en, 1, "no restart");
        wait_for(RUN, 1'b0, 10, n);
        chk(regulate_en, 0, "no second trip");
        avg_req = 2'h0;
        mon_req = 1'b0;
        wait_for(PG, 1'b0, RETRY_T + TD1_T + RAMP_T + 30, n);
        chk(pg_oe, 0, "no recovery after fault");
    endtask

    task automatic t_disable;
        int n;
        mon_req = 1'b1;
        wait_for(RUN, 1'b0, 8, n);
        tick(5);
        enable = 1'b0;
        mon_req = 1'b0;
        tick(RETRY_T + TD1_T + 20);
        chk({regulate_en, pg_oe}, 2'b01, "retry while disabled");
        t_start();
    endtask

    task automatic t_ov;
        int n;
        ov_req = 1'b1;
        wait_for(LAT, 1'b1, 8, n);
        chk(latched_off, 1, "no latch-off");
        chk({regulate_en, hs, ls}, 7'h07, "ov gate state");
        ov_req = 1'b0;
        tick(100);
        chk({latched_off, regulate_en, pg_oe}, 3'b101, "latch lost");
        reset_n = 1'b0;
        tick(2);
        chk({latched_off, regulate_en, pg_oe}, 3'b001, "reset ignored");
        reset_n = 1'b1;
        t_start();
    endtask

    initial
    begin
        enable = 1'b1;
        tick(8);
        chk({hs, ls, regulate_en, latched_off, boost, pg_oe}, 10'h001,
            "reset values");
        reset_n = 1'b1;
        t_start();
        t_uv();
        t_limit();
        t_boost();
        t_ocp(0);
        t_ocp(1);
        t_disable();
        t_ov();
        results();
    end
endmodule
